// file: hdl/bcs_top.sv
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bcs_top #(
	parameter int TMR_W = bcs_pkg::TMR_W,
	parameter int PRESCALE = bcs_pkg::PRESCALE
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// straps and control pins
	input wire logic [1:0] i_mode_strap,
	input wire logic i_timer_cap_present,
	input wire logic i_shutdown_input,
	input wire logic i_temp_fault,
	// sense comparators
	input wire logic i_fb_below_precond,
	input wire logic i_fb_near_float,
	input wire logic i_fb_below_recharge,
	input wire logic i_fb_below_bulk_restart,
	input wire logic i_low_current,
	input wire logic i_gate_settled,
	input wire logic i_instant_on,
	input wire logic i_vin_below_reg,
	// converter and path switch
	output logic o_path_switch_gate,
	output logic o_use_max_output_feedback,
	output logic o_demand_charge_en,
	output logic o_demand_fifteenth,
	output logic o_demand_cv,
	output logic o_demand_float_ref,
	output logic o_demand_vin_reduce,
	// status pins
	output logic o_status_output_one,
	output logic o_status_output_two
);
	bcs_pkg::bcs_state_e state_ff;
	bcs_pkg::bcs_state_e nxt_state;
	bcs_pkg::bcs_state_e start_state;
	bcs_pkg::bcs_mode_e mode_ff;
	logic strap_done_ff;
	logic ctrl_en_ff;
	logic tterm_ff;
	logic [TMR_W-1:0] eoc_cnt_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic acc;
	logic [31:0] rd_data;
	logic run_ok;
	logic active;
	logic timer_en;
	logic eoc_ok;
	logic eighth_ok;
	logic c10_ok;
	logic c10_hit;
	logic tmr_clr;
	logic [1:0] nxt_code;

	bcs_tmr_if #(.W(TMR_W)) tmr_bus();

	// ****************************************
	// timer
	// ****************************************

	bcs_timer #(.W(TMR_W), .PRESCALE(PRESCALE)) u_timer (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(tmr_bus)
	);

	assign timer_en = i_timer_cap_present;
	assign tmr_bus.eoc_cnt = eoc_cnt_ff;
	assign eoc_ok = timer_en && tmr_bus.eoc;
	assign eighth_ok = timer_en && tmr_bus.eighth;
	// timer holds during a temperature pause rather than restarting
	assign tmr_bus.run = timer_en && (state_ff == bcs_pkg::ST_PRE || state_ff == bcs_pkg::ST_CC
		|| state_ff == bcs_pkg::ST_CV);
	assign tmr_bus.clr = tmr_clr;

	// ****************************************
	// mode strap
	// ****************************************

	// strap caught on the first edge after reset release, never in reset
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mode_ff <= bcs_pkg::MODE_CCCV;
			strap_done_ff <= 1'b0;
		end
		else if (!strap_done_ff)
		begin
			strap_done_ff <= 1'b1;
			if (i_mode_strap == bcs_pkg::MODE_LEAD)
				mode_ff <= bcs_pkg::MODE_LEAD;
			else if (i_mode_strap == bcs_pkg::MODE_CC)
				mode_ff <= bcs_pkg::MODE_CC;
			// ground, or the unused code, selects CC/CV
			else
				mode_ff <= bcs_pkg::MODE_CCCV;
		end
	end

	// ****************************************
	// charge sequencer
	// ****************************************

	assign run_ok = ctrl_en_ff && !i_shutdown_input && strap_done_ff;
	assign active = (state_ff == bcs_pkg::ST_PRE) || (state_ff == bcs_pkg::ST_CC)
		|| (state_ff == bcs_pkg::ST_CV) || (state_ff == bcs_pkg::ST_FLOAT);
	assign c10_ok = i_gate_settled && !i_instant_on && !o_path_switch_gate;
	assign c10_hit = i_low_current && c10_ok;
	assign start_state = (mode_ff != bcs_pkg::MODE_CC && i_fb_below_precond) ?
		bcs_pkg::ST_PRE : bcs_pkg::ST_CC;

	// next state; disable outranks faults, faults outrank progress
	always_comb
	begin
		nxt_state = state_ff;
		tmr_clr = 1'b0;
		if (!run_ok)
			nxt_state = bcs_pkg::ST_OFF;
		else if (active && i_temp_fault)
			nxt_state = bcs_pkg::ST_TEMP;
		else
		begin
			case (state_ff)
				bcs_pkg::ST_OFF:
				begin
					nxt_state = start_state;
					tmr_clr = 1'b1;
				end
				bcs_pkg::ST_TEMP:
				begin
					if (!i_temp_fault)
						nxt_state = start_state;
				end
				bcs_pkg::ST_PRE:
				begin
					if (eighth_ok)
						nxt_state = bcs_pkg::ST_BAD;
					else if (!i_fb_below_precond)
						nxt_state = bcs_pkg::ST_CC;
				end
				bcs_pkg::ST_CC:
				begin
					if (mode_ff == bcs_pkg::MODE_CC)
					begin
						if (eoc_ok)
							nxt_state = bcs_pkg::ST_DONE;
					end
					else if (i_fb_below_precond)
						nxt_state = bcs_pkg::ST_PRE;
					else if (i_fb_near_float)
					begin
						nxt_state = bcs_pkg::ST_CV;
						tmr_clr = 1'b1;
					end
				end
				bcs_pkg::ST_CV:
				begin
					if (mode_ff == bcs_pkg::MODE_LEAD)
					begin
						if (c10_hit || eoc_ok)
							nxt_state = bcs_pkg::ST_FLOAT;
					end
					else if (tterm_ff && eoc_ok)
						nxt_state = bcs_pkg::ST_DONE;
					else if (!tterm_ff && c10_hit)
						nxt_state = bcs_pkg::ST_DONE;
				end
				bcs_pkg::ST_FLOAT:
				begin
					if (i_fb_below_bulk_restart)
					begin
						nxt_state = bcs_pkg::ST_CC;
						tmr_clr = 1'b1;
					end
				end
				bcs_pkg::ST_DONE:
				begin
					// CC mode waits for a power or shutdown cycle
					if (mode_ff == bcs_pkg::MODE_CCCV && i_fb_below_recharge)
					begin
						nxt_state = start_state;
						tmr_clr = 1'b1;
					end
				end
				default:
					nxt_state = state_ff;
			endcase
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state_ff <= bcs_pkg::ST_OFF;
		else
			state_ff <= nxt_state;
	end

	// ****************************************
	// converter and status outputs
	// ****************************************

	always_comb
	begin
		if (nxt_state == bcs_pkg::ST_BAD)
			nxt_code = bcs_pkg::STAT_BAD;
		else if (nxt_state == bcs_pkg::ST_TEMP)
			nxt_code = bcs_pkg::STAT_TEMP;
		else if (nxt_state != bcs_pkg::ST_OFF && nxt_state != bcs_pkg::ST_DONE && !i_low_current)
			nxt_code = bcs_pkg::STAT_CHG;
		else
			nxt_code = bcs_pkg::STAT_NOTCHG;
	end

	// outputs follow the next state so they line up with state_ff
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_path_switch_gate <= 1'b1;
			o_use_max_output_feedback <= 1'b1;
			o_demand_charge_en <= 1'b0;
			o_demand_fifteenth <= 1'b0;
			o_demand_cv <= 1'b0;
			o_demand_float_ref <= 1'b0;
			o_status_output_one <= 1'b0;
			o_status_output_two <= 1'b0;
		end
		else
		begin
			o_path_switch_gate <= (nxt_state == bcs_pkg::ST_OFF) || (nxt_state == bcs_pkg::ST_DONE)
				|| (nxt_state == bcs_pkg::ST_BAD) || (nxt_state == bcs_pkg::ST_TEMP);
			o_use_max_output_feedback <= (nxt_state == bcs_pkg::ST_OFF)
				|| (nxt_state == bcs_pkg::ST_DONE) || (nxt_state == bcs_pkg::ST_BAD)
				|| (nxt_state == bcs_pkg::ST_TEMP);
			o_demand_charge_en <= (nxt_state == bcs_pkg::ST_PRE) || (nxt_state == bcs_pkg::ST_CC)
				|| (nxt_state == bcs_pkg::ST_CV) || (nxt_state == bcs_pkg::ST_FLOAT);
			o_demand_fifteenth <= (nxt_state == bcs_pkg::ST_PRE) || (nxt_state == bcs_pkg::ST_FLOAT);
			o_demand_cv <= (nxt_state == bcs_pkg::ST_CV) || (nxt_state == bcs_pkg::ST_FLOAT);
			o_demand_float_ref <= (nxt_state == bcs_pkg::ST_FLOAT);
			o_status_output_one <= nxt_code[0];
			o_status_output_two <= nxt_code[1];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_demand_vin_reduce <= 1'b0;
		else
			o_demand_vin_reduce <= i_vin_below_reg;
	end

	// ****************************************
	// register bus
	// ****************************************

	// only whole-word transfers are taken; others complete with no effect
	assign acc = i_hsel && i_htrans[1] && i_hready && (i_hsize == bcs_pkg::HSIZE_WORD);

	// address phase capture for writes
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h0;
		end
		else
		begin
			wr_pend_ff <= acc && i_hwrite;
			wr_addr_ff <= i_haddr[7:0];
		end
	end

	// control and end-of-cycle count written in the data phase
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_en_ff <= bcs_pkg::CTRL_EN_RST;
			tterm_ff <= bcs_pkg::CTRL_TTERM_RST;
			eoc_cnt_ff <= TMR_W'(bcs_pkg::EOC_RST);
		end
		else if (wr_pend_ff && wr_addr_ff == bcs_pkg::OFS_CTRL)
		begin
			ctrl_en_ff <= i_hwdata[bcs_pkg::CTRL_EN_BIT];
			tterm_ff <= i_hwdata[bcs_pkg::CTRL_TTERM_BIT];
		end
		else if (wr_pend_ff && wr_addr_ff == bcs_pkg::OFS_EOC)
			eoc_cnt_ff <= i_hwdata[TMR_W-1:0];
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rd_data = 32'h0;
		if (i_haddr[7:0] == bcs_pkg::OFS_CTRL)
		begin
			rd_data[bcs_pkg::CTRL_EN_BIT] = ctrl_en_ff;
			rd_data[bcs_pkg::CTRL_TTERM_BIT] = tterm_ff;
		end
		else if (i_haddr[7:0] == bcs_pkg::OFS_EOC)
			rd_data[TMR_W-1:0] = eoc_cnt_ff;
		else if (i_haddr[7:0] == bcs_pkg::OFS_STATUS)
		begin
			rd_data[bcs_pkg::ST_STATE_LSB +: 3] = state_ff;
			rd_data[bcs_pkg::ST_MODE_LSB +: 2] = mode_ff;
			rd_data[bcs_pkg::ST_CODE_LSB +: 2] = {o_status_output_two, o_status_output_one};
			rd_data[bcs_pkg::ST_TMREN_BIT] = timer_en;
			rd_data[bcs_pkg::ST_C10OK_BIT] = c10_ok;
			rd_data[bcs_pkg::ST_LOWI_BIT] = i_low_current;
		end
		else if (i_haddr[7:0] == bcs_pkg::OFS_TIMER)
			rd_data[TMR_W-1:0] = tmr_bus.count;
	end

	// zero wait state: read data sampled at the address phase edge
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_hrdata <= 32'h0;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			if (acc && !i_hwrite)
				o_hrdata <= rd_data;
		end
	end

	// ****************************************
	// checks
	// ****************************************

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	property p_gate_off;
		(state_ff == bcs_pkg::ST_OFF) |-> (o_path_switch_gate && o_use_max_output_feedback
			&& !o_demand_charge_en);
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("gate not off while idle");

	property p_c10_mask;
		(state_ff == bcs_pkg::ST_CV && run_ok && !i_temp_fault && !c10_ok && !eoc_ok)
			|=> (state_ff == bcs_pkg::ST_CV);
	endproperty
	a_c10_mask: assert property (p_c10_mask) else $error("C/10 acted while masked");

	property p_vin_reg;
		i_vin_below_reg |=> o_demand_vin_reduce;
	endproperty
	a_vin_reg: assert property (p_vin_reg) else $error("input regulation ignored");

	property p_no_timer;
		(state_ff == bcs_pkg::ST_PRE && !i_timer_cap_present) |=> (state_ff != bcs_pkg::ST_BAD);
	endproperty
	a_no_timer: assert property (p_no_timer) else $error("bad battery without timer");

	property p_cc_eoc;
		(state_ff == bcs_pkg::ST_CC && mode_ff == bcs_pkg::MODE_CC && eoc_ok && run_ok
			&& !i_temp_fault) |=> (state_ff == bcs_pkg::ST_DONE) ##1 o_path_switch_gate;
	endproperty
	a_cc_eoc: assert property (p_cc_eoc) else $error("timed CC did not end");

	property p_la_float;
		(state_ff == bcs_pkg::ST_CV && mode_ff == bcs_pkg::MODE_LEAD && eoc_ok && run_ok
			&& !i_temp_fault) |=> (state_ff == bcs_pkg::ST_FLOAT && o_demand_float_ref);
	endproperty
	a_la_float: assert property (p_la_float) else $error("no forced float");

	property p_badbat;
		(state_ff == bcs_pkg::ST_PRE && eighth_ok && run_ok && !i_temp_fault)
			|=> (state_ff == bcs_pkg::ST_BAD) && !o_demand_charge_en
			&& {o_status_output_two, o_status_output_one} == bcs_pkg::STAT_BAD;
	endproperty
	a_badbat: assert property (p_badbat) else $error("bad battery not flagged");

	property p_pre_limit;
		(state_ff == bcs_pkg::ST_PRE) |-> o_demand_fifteenth;
	endproperty
	a_pre_limit: assert property (p_pre_limit) else $error("precondition current not limited");

	property p_cv_entry;
		(state_ff == bcs_pkg::ST_CC && mode_ff != bcs_pkg::MODE_CC && !i_fb_below_precond
			&& i_fb_near_float && run_ok && !i_temp_fault)
			|=> (state_ff == bcs_pkg::ST_CV && tmr_bus.count == '0 && o_demand_cv);
	endproperty
	a_cv_entry: assert property (p_cv_entry) else $error("CV entry or timer restart missed");

	property p_recharge;
		(state_ff == bcs_pkg::ST_DONE && mode_ff == bcs_pkg::MODE_CCCV && i_fb_below_recharge
			&& run_ok) |=> (state_ff == bcs_pkg::ST_PRE || state_ff == bcs_pkg::ST_CC);
	endproperty
	a_recharge: assert property (p_recharge) else $error("no automatic recharge");

	property p_stat_one;
		// a bad battery keeps its fault code though no current flows then
		(i_low_current && state_ff != bcs_pkg::ST_PRE && state_ff != bcs_pkg::ST_BAD)
			|=> !o_status_output_one;
	endproperty
	a_stat_one: assert property (p_stat_one) else $error("status one shows charging below C/10");
endmodule
`default_nettype wire

// file: inc/bcs_pkg.sv
`default_nettype none
// ****************************************
// charge sequencer constants
// ****************************************
package bcs_pkg;
	// register offsets, bytes, decoded on haddr[7:0]
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_EOC = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_TIMER = 8'h0c;
	// control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_TTERM_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic CTRL_TTERM_RST = 1'b0;
	// status fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_MODE_LSB = 4;
	localparam int ST_CODE_LSB = 8;
	localparam int ST_TMREN_BIT = 12;
	localparam int ST_C10OK_BIT = 13;
	localparam int ST_LOWI_BIT = 14;
	// timer
	localparam int TMR_W = 24;
	localparam logic [23:0] EOC_RST = 24'h002a30;
	localparam int PRESCALE = 1000;
	localparam int EIGHTH_SHIFT = 3;
	// bus
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// status pin codes {two, one}
	localparam logic [1:0] STAT_NOTCHG = 2'h0;
	localparam logic [1:0] STAT_CHG = 2'h1;
	localparam logic [1:0] STAT_TEMP = 2'h2;
	localparam logic [1:0] STAT_BAD = 2'h3;
	// sequencer states
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_PRE = 3'b001,
		ST_CC = 3'b010,
		ST_CV = 3'b011,
		ST_FLOAT = 3'b100,
		ST_DONE = 3'b101,
		ST_BAD = 3'b110,
		ST_TEMP = 3'b111
	} bcs_state_e;
	// strap codes: ground, supply rail, open
	typedef enum logic [1:0] {
		MODE_CCCV = 2'b00,
		MODE_LEAD = 2'b01,
		MODE_CC = 2'b10
	} bcs_mode_e;
endpackage
`default_nettype wire

// file: inc/bcs_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// sequencer to timer link
// ****************************************
interface bcs_tmr_if #(parameter int W = 24);
	logic clr;
	logic run;
	logic [W-1:0] eoc_cnt;
	logic [W-1:0] count;
	logic eoc;
	logic eighth;
	modport tmr (input clr, input run, input eoc_cnt, output count, output eoc, output eighth);
	modport ctl (output clr, output run, output eoc_cnt, input count, input eoc, input eighth);
endinterface
`default_nettype wire

// file: hdl/bcs_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// end-of-cycle charge timer
// ****************************************
module bcs_timer #(
	parameter int W = 24,
	parameter int PRESCALE = 1000
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// sequencer side
	bcs_tmr_if.tmr bus
);
	logic [15:0] pre_ff;
	logic [W-1:0] count_ff;
	logic tick;

	// one-cycle enable from the prescaler, only while running
	assign tick = bus.run && (pre_ff == 16'(PRESCALE - 1));

	// prescaler restarts with the count so every period is whole
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pre_ff <= 16'h0;
		else if (bus.clr || !bus.run || tick)
			pre_ff <= 16'h0;
		else
			pre_ff <= pre_ff + 16'h1;
	end

	// count saturates so a long stall cannot wrap into a false start
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count_ff <= '0;
		else if (bus.clr)
			count_ff <= '0;
		else if (tick && (count_ff != {W{1'b1}}))
			count_ff <= count_ff + W'(1);
	end

	// compare taps
	assign bus.count = count_ff;
	assign bus.eoc = (count_ff >= bus.eoc_cnt);
	assign bus.eighth = (count_ff >= (bus.eoc_cnt >> bcs_pkg::EIGHTH_SHIFT));
endmodule
`default_nettype wire

// file: sim/bcs_sense_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// sense front end and path switch model
// ****************************************
module bcs_sense_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// bench controls
	input wire logic [7:0] i_vfb,
	input wire logic i_cur_low,
	// path switch gate from the sequencer
	input wire logic i_gate,
	// comparator flags
	output logic o_below_precond,
	output logic o_near_float,
	output logic o_below_recharge,
	output logic o_below_bulk,
	output logic o_low_current,
	output logic o_gate_settled
);
	logic [5:0] settle_ff;
	assign o_below_precond = i_vfb < 8'h8c;
	assign o_near_float = i_vfb >= 8'hc6;
	assign o_below_recharge = i_vfb < 8'hc3;
	assign o_below_bulk = i_vfb < 8'haf;
	assign o_low_current = i_cur_low;
	// slow gate node: settles long after it is pulled low, so early C/10 stays masked
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			settle_ff <= 6'h00;
		else if (i_gate)
			settle_ff <= 6'h00;
		else if (settle_ff != 6'h3f)
			settle_ff <= settle_ff + 6'h01;
	end
	assign o_gate_settled = settle_ff == 6'h3f;
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = bcs_pkg::HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] strap = 2'h0;
	logic cap = 1'b0;
	logic shutdown_input = 1'b0;
	logic temp = 1'b0;
	logic [7:0] battery_feedback = 8'h64;
	logic cur_low = 1'b0;
	logic inst = 1'b0;
	logic vinr = 1'b0;
	logic [31:0] hrdata, r;
	logic hready, hresp, bp, nf, br, bb, lc, gs, gate, maxfb, chg, fif, cv, fref, vred, s1, s2;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	// ****************************************
	// clock, design and far side
	// ****************************************
	always #5 clk = ~clk;
	bcs_top #(.PRESCALE(2)) i_bcs_top (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_mode_strap(strap), .i_timer_cap_present(cap),
		.i_shutdown_input(shutdown_input), .i_temp_fault(temp), .i_fb_below_precond(bp),
		.i_fb_near_float(nf), .i_fb_below_recharge(br), .i_fb_below_bulk_restart(bb),
		.i_low_current(lc), .i_gate_settled(gs), .i_instant_on(inst),
		.i_vin_below_reg(vinr), .o_path_switch_gate(gate),
		.o_use_max_output_feedback(maxfb), .o_demand_charge_en(chg),
		.o_demand_fifteenth(fif), .o_demand_cv(cv), .o_demand_float_ref(fref),
		.o_demand_vin_reduce(vred), .o_status_output_one(s1), .o_status_output_two(s2));
	bcs_sense_model i_bcs_sense_model (.i_clk(clk), .i_rst_n(rst_n), .i_vfb(battery_feedback),
		.i_cur_low(cur_low), .i_gate(gate), .o_below_precond(bp), .o_near_float(nf),
		.o_below_recharge(br), .o_below_bulk(bb), .o_low_current(lc), .o_gate_settled(gs));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic print_verdict();
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %0t word got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %0t bit got %b exp %b", $time, g, e);
		end
	endtask
	// one single word transfer; no wait count assumed, the timeout cuts a hang
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		q = hrdata;
	endtask
	// poll the state field, bounded
	task automatic wait_st(input logic [2:0] s);
		int n;
		n = 0;
		ahb(1'b0, bcs_pkg::OFS_STATUS, 32'h0, r);
		while (r[2:0] !== s && n < 150)
		begin
			ahb(1'b0, bcs_pkg::OFS_STATUS, 32'h0, r);
			n++;
		end
		chk_w({29'h0, r[2:0]}, {29'h0, s});
	endtask
	task automatic do_reset(input logic [1:0] m);
		rst_n <= 1'b0;
		strap <= m;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		ahb(1'b0, bcs_pkg::OFS_STATUS, 32'h0, r);
		chk_w({30'h0, r[5:4]}, {30'h0, m});
		ahb(1'b1, bcs_pkg::OFS_EOC, 32'h10, r);
	endtask
	task automatic ctrl(input logic [31:0] v);
		ahb(1'b1, bcs_pkg::OFS_CTRL, v, r);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		chk_b(gate, 1'b1);
		chk_b(maxfb, 1'b1);
		chk_b(chg, 1'b0);
		ahb(1'b0, bcs_pkg::OFS_CTRL, 32'h0, r);
		chk_w(r, 32'h0);
		chk_b(hresp, 1'b0);
		ahb(1'b1, 8'h10, 32'hffff, r);
		ahb(1'b0, 8'h10, 32'h0, r);
		chk_w(r, 32'h0);
		ahb(1'b0, bcs_pkg::OFS_EOC, 32'h0, r);
		chk_w(r, 32'h10);
		vinr <= 1'b1;
		repeat (3) @(posedge clk);
		chk_b(vred, 1'b1);
		chk_b(maxfb, 1'b1);
		vinr <= 1'b0;
		repeat (2) @(posedge clk);
		chk_b(vred, 1'b0);
	endtask
	task automatic t_c10();
		ctrl(32'h1);
		wait_st(3'h1);
		chk_b(fif, 1'b1);
		chk_w({30'h0, s2, s1}, 32'h1);
		battery_feedback <= 8'h96;
		wait_st(3'h2);
		chk_b(fif, 1'b0);
		battery_feedback <= 8'hc8;
		wait_st(3'h3);
		chk_b(cv, 1'b1);
		repeat (70) @(posedge clk);
		inst <= 1'b1;
		cur_low <= 1'b1;
		repeat (20) @(posedge clk);
		wait_st(3'h3);
		chk_w({30'h0, s2, s1}, 32'h0);
		inst <= 1'b0;
		wait_st(3'h5);
		chk_b(gate, 1'b1);
		battery_feedback <= 8'hc0;
		wait_st(3'h2);
		battery_feedback <= 8'hc8;
		wait_st(3'h3);
		wait_st(3'h5);
	endtask
	task automatic t_bad();
		ctrl(32'h0);
		battery_feedback <= 8'h64;
		cur_low <= 1'b0;
		ctrl(32'h1);
		repeat (100) @(posedge clk);
		wait_st(3'h1);
		cap <= 1'b1;
		wait_st(3'h6);
		chk_w({30'h0, s2, s1}, 32'h3);
		chk_b(chg, 1'b0);
	endtask
	task automatic t_timer();
		ctrl(32'h0);
		battery_feedback <= 8'hc8;
		cur_low <= 1'b1;
		ctrl(32'h3);
		wait_st(3'h3);
		chk_w({30'h0, r[9:8]}, 32'h0);
		wait_st(3'h5);
		chk_b(gate, 1'b1);
		chk_b(chg, 1'b0);
	endtask
	task automatic t_cc();
		do_reset(2'h2);
		battery_feedback <= 8'h64;
		cur_low <= 1'b0;
		ctrl(32'h1);
		wait_st(3'h2);
		wait_st(3'h5);
		repeat (40) @(posedge clk);
		wait_st(3'h5);
		shutdown_input <= 1'b1;
		wait_st(3'h0);
		chk_b(gate, 1'b1);
		shutdown_input <= 1'b0;
		wait_st(3'h2);
	endtask
	task automatic t_lead();
		do_reset(2'h1);
		battery_feedback <= 8'hc8;
		ctrl(32'h1);
		wait_st(3'h4);
		chk_b(fref, 1'b1);
		chk_b(fif, 1'b1);
		// float holds until the battery sags to the bulk restart level
		battery_feedback <= 8'ha0;
		wait_st(3'h2);
		chk_b(fref, 1'b0);
		chk_b(fif, 1'b0);
		temp <= 1'b1;
		wait_st(3'h7);
		chk_w({30'h0, s2, s1}, 32'h2);
		temp <= 1'b0;
	endtask
	// ****************************************
	// main sequence and hang guard
	// ****************************************
	initial
	begin
		do_reset(2'h0);
		t_regs();
		t_c10();
		t_bad();
		t_timer();
		t_cc();
		t_lead();
		print_verdict();
	end
	// the whole run needs under a thousand cycles; far beyond that is a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			print_verdict();
		end
	end
endmodule
`default_nettype wire
